/* File: flash_cmd_pkg.sv */
// Shared constants and types for the flash command decoder
package flash_cmd_pkg;

	// ************************************************
	// Widths
	// ************************************************
	localparam int ADDR_W = 20;
	localparam int SECT_W = 6;
	localparam int BANK_W = 1;
	localparam int DATA_W = 32;
	localparam int CFG_W = 16;

	// ************************************************
	// Unlock addresses and command codes
	// ************************************************
	localparam logic [10:0] UNL_A1 = 11'h555;
	localparam logic [10:0] UNL_A2 = 11'h2aa;
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam logic [7:0] CMD_UNL1 = 8'haa;
	localparam logic [7:0] CMD_UNL2 = 8'h55;
	localparam logic [7:0] CMD_AUTO = 8'h90;
	localparam logic [7:0] CMD_PGM = 8'ha0;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] CMD_CHIP = 8'h10;
	localparam logic [7:0] CMD_SECT = 8'h30;
	localparam logic [7:0] CMD_SUSP = 8'hb0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [7:0] CMD_CFG = 8'hd0;
	localparam logic [7:0] CMD_BYP = 8'h20;
	localparam logic [7:0] CMD_SEC_IN = 8'h88;
	localparam logic [7:0] CMD_EXIT = 8'h00;
	localparam logic [7:0] CMD_PWD_PGM = 8'h38;
	localparam logic [7:0] CMD_PWD_VFY = 8'hc8;
	localparam logic [7:0] CMD_PWD_UNL = 8'h28;
	localparam logic [7:0] CMD_NV = 8'h60;
	localparam logic [7:0] CMD_NV_PGM = 8'h68;
	localparam logic [7:0] CMD_NV_CHK = 8'h48;
	localparam logic [7:0] CMD_NV_ERA = 8'h60;
	localparam logic [7:0] CMD_NV_ERA_CHK = 8'h40;
	localparam logic [7:0] CMD_VOL = 8'h48;
	localparam logic [7:0] CMD_VOL_STAT = 8'h58;
	localparam logic [7:0] CMD_FREEZE = 8'h78;

	// ************************************************
	// Low address patterns, as {A5,A4,A3,A1,A0}; PAT_ALL as {A5,A4,A3,A2,A1,A0}
	// ************************************************
	localparam logic [4:0] PAT_PWM = 5'h06;
	localparam logic [4:0] PAT_PSM = 5'h0a;
	localparam logic [4:0] PAT_SEC = 5'h0e;
	localparam logic [5:0] PAT_ALL = 6'h3a;

	// ************************************************
	// Identification read offsets, status values and password operation codes
	// ************************************************
	localparam logic [7:0] ID_MAKER = 8'h00;
	localparam logic [7:0] ID_DEV1 = 8'h01;
	localparam logic [7:0] ID_PPB = 8'h02;
	localparam logic [7:0] ID_DEV2 = 8'h0e;
	localparam logic [7:0] ID_DEV3 = 8'h0f;
	localparam logic [DATA_W-1:0] PPB_SET_VAL = 32'h0000_0000;
	localparam logic [DATA_W-1:0] PPB_CLR_VAL = 32'h0000_0001;
	localparam logic [1:0] PWD_OP_PGM = 2'h0;
	localparam logic [1:0] PWD_OP_VFY = 2'h1;
	localparam logic [1:0] PWD_OP_UNL = 2'h2;

	// ************************************************
	// Types
	// ************************************************
	typedef struct packed {
		logic valid;
		logic we;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} bus_cyc_t;

	typedef struct packed {
		logic dyb_we;
		logic dyb_val;
		logic ppb_set;
		logic ppb_clr_all;
		logic [SECT_W-1:0] sect;
	} lock_wr_t;

	typedef enum logic [4:0] {
		ST_READ, ST_U1, ST_U2, ST_AUTO, ST_PGM, ST_E1, ST_E2, ST_E3,
		ST_CFG, ST_PWD, ST_NV, ST_NV_PROG, ST_NV_ERA, ST_NV_CHK,
		ST_DYB_WR, ST_DYB_STAT, ST_BYP, ST_BYP_PGM, ST_BYP_ERA, ST_BYP_RST
	} cmd_st_t;

	typedef struct packed {
		cmd_st_t st;
		logic bypass;
		logic secure_map;
		logic suspended;
		logic [1:0] pwd_op;
		logic [63:0] password;
		logic [1:0] pwd_ok;
		logic ppb_freeze;
		logic pw_lock;
		logic pers_lock;
		logic secure_lock;
		logic [CFG_W-1:0] cfg;
		logic [SECT_W-1:0] erase_sect;
		logic erase_chip;
		logic rd_strobe;
		logic rd_status;
		logic [DATA_W-1:0] rd_data;
		logic pgm_req;
		logic erase_req;
		logic [ADDR_W-1:0] op_addr;
		logic [DATA_W-1:0] op_data;
		logic suspend_req;
		logic resume_req;
		lock_wr_t lw;
	} dec_state_t;

	localparam dec_state_t DEC_RST = '0;

endpackage

/* File: sector_lock_store.sv */
// Per-sector volatile and persistent lock bits
`timescale 1ns/1ns
`default_nettype none
module sector_lock_store import flash_cmd_pkg::*; #(
	parameter int N_SECT = 2**SECT_W
) (
	input wire logic ref_clk, // 10 MHz clock
	input wire logic sys_rst, // Sync reset
	input wire lock_wr_t wr, // Lock update
	input wire logic [SECT_W-1:0] rd_sect, // Sector looked up
	output logic dyb_bit, // Volatile lock of rd_sect
	output logic ppb_bit // Persistent lock of rd_sect
);

	typedef struct packed {
		logic [N_SECT-1:0] volatile_sector_lock;
		logic [N_SECT-1:0] persistent_sector_lock;
	} lock_state_t;

	lock_state_t s_r;
	lock_state_t s_nxt;

	if (N_SECT != 2**SECT_W) begin : g_chk
		$error("N_SECT must equal 2**SECT_W");
	end

	always_comb begin
		s_nxt = s_r;
		if (wr.dyb_we) begin
			s_nxt.volatile_sector_lock[wr.sect] = wr.dyb_val;
		end
		if (wr.ppb_set) begin
			s_nxt.persistent_sector_lock[wr.sect] = 1'b1;
		end
		if (wr.ppb_clr_all) begin
			s_nxt.persistent_sector_lock = '0;
		end
	end

	// Persistent bits have no backing store here, so reset clears them too
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign dyb_bit = s_r.volatile_sector_lock[rd_sect];
	assign ppb_bit = s_r.persistent_sector_lock[rd_sect];

endmodule // sector_lock_store
`default_nettype wire

/* File: flash_protection_command_decoder.sv */
// Write-cycle command decoder with sector protection commands
// Notes on behaviour
// - Unlock cycles compare only address bits A10-A0 and data bits DQ7-DQ0.
// - Write of F0 returns to read, or to bypass in bypass mode, keeping any erase suspend.
// - In read-array state, plain reads return array data with no commands.
// - Part code spans fourth, fifth and sixth reads; all three must be read.
// - Short bypass commands only after bypass entry; 90/00 exits bypass.
// - Suspend only during sector erase, with bank; suspended allows reads, programs, query.
// - Resume honoured only while erase-suspended, addressed to the bank.
// - Configuration write sequence ignored while busy or suspended.
// - 555/AA, 2AA/55, 555/88 enters secure area mapping.
// - 555/AA, 2AA/55, 555/90, then XX/00 leaves secure area.
// - 555/AA, 2AA/55, 555/38, then word; A0 picks password half.
// - After 60, 68 programs bit, 48 plus read verify; reissue on 0.
// - After 60, 60 at 111010 erases all persistent locks, 40 then verify.
// - Query read at sector plus 02 gives 00 when locked, 01 otherwise.
// - Status reads of further sectors need no new command sequence.
// - Protection status reads give DQ0 high when protected, low otherwise.
// - 555/48 then sector write: data bit 0 sets or clears volatile lock.
// - Mode lock bits use 60, 68, 48 at patterns 001X10 and 010X10.
// - After 60, read at 011X10 gives secure area lock on DQ0.
`timescale 1ns/1ns
`default_nettype none
module flash_protection_command_decoder import flash_cmd_pkg::*; #(
	parameter logic [DATA_W-1:0] MAKER_CODE = 32'h0000_0011, // Arbitrary value
	parameter logic [DATA_W-1:0] DEV_CODE1 = 32'h0000_0022, // Arbitrary value
	parameter logic [DATA_W-1:0] DEV_CODE2 = 32'h0000_0033, // Arbitrary value
	parameter logic [DATA_W-1:0] DEV_CODE3 = 32'h0000_0044 // Arbitrary value
) (
	input wire logic ref_clk, // 10 MHz clock
	input wire logic sys_rst, // Sync reset, active high
	input wire bus_cyc_t cyc, // One bus cycle per valid pulse
	input wire logic embed_busy, // Embedded program or erase running
	input wire logic erase_running, // Sector erase running
	output logic rd_strobe, // Read answer pulse
	output logic rd_status, // Answer is status, not array
	output logic [DATA_W-1:0] rd_data, // Status read data
	output logic pgm_req, // Program request pulse
	output logic erase_req, // Erase request pulse
	output logic erase_chip, // Last erase was whole chip
	output logic [ADDR_W-1:0] op_addr, // Program or erase address
	output logic [DATA_W-1:0] op_data, // Program data
	output logic suspend_req, // Erase suspend pulse
	output logic resume_req, // Erase resume pulse
	output logic suspended, // Erase suspend mode
	output logic bypass, // Unlock bypass mode
	output logic secure_map, // Array maps to secure area
	output logic autoselect, // Query mode
	output logic [CFG_W-1:0] cfg, // Configuration word
	output logic pwd_unlocked // Both password halves matched
);

	// ************************************************
	// Helpers
	// ************************************************
	function automatic logic [SECT_W-1:0] sect_of(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1 -: SECT_W];
	endfunction

	function automatic logic [BANK_W-1:0] bank_of(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1 -: BANK_W];
	endfunction

	function automatic logic [4:0] pat_of(input logic [ADDR_W-1:0] a);
		return {a[5:3], a[1:0]};
	endfunction

	dec_state_t s_r;
	dec_state_t s_nxt;
	logic dyb_bit;
	logic ppb_bit;
	logic nv_bit;
	logic [7:0] d8;
	logic unl1;
	logic unl2;
	logic at555;
	logic protect;
	logic capture;
	logic bank_ok;
	cmd_st_t idle;

	sector_lock_store #(
		.N_SECT(2**SECT_W)
	) u_locks (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.wr(s_r.lw),
		.rd_sect(sect_of(cyc.addr)),
		.dyb_bit(dyb_bit),
		.ppb_bit(ppb_bit)
	);

	// ************************************************
	// Cycle decode
	// ************************************************
	assign d8 = cyc.data[7:0];
	assign at555 = cyc.addr[10:0] == UNL_A1;
	assign unl1 = at555 && d8 == CMD_UNL1;
	assign unl2 = cyc.addr[10:0] == UNL_A2 && d8 == CMD_UNL2;
	assign protect = ppb_bit || dyb_bit;
	assign bank_ok = bank_of(cyc.addr) == s_r.erase_sect[SECT_W-1 -: BANK_W];
	// States whose next write is data, where F0 is an ordinary value
	assign capture = s_r.st inside {ST_PGM, ST_BYP_PGM, ST_CFG, ST_PWD, ST_DYB_WR};
	assign idle = s_r.bypass ? ST_BYP : ST_READ;

	always_comb begin
		unique case (pat_of(cyc.addr))
			PAT_SEC: nv_bit = s_r.secure_lock;
			PAT_PWM: nv_bit = s_r.pw_lock;
			PAT_PSM: nv_bit = s_r.pers_lock;
			default: nv_bit = ppb_bit;
		endcase
	end

	// ************************************************
	// Command state machine
	// ************************************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.rd_strobe = 1'b0;
		s_nxt.pgm_req = 1'b0;
		s_nxt.erase_req = 1'b0;
		s_nxt.suspend_req = 1'b0;
		s_nxt.resume_req = 1'b0;
		s_nxt.lw = '0;
		if (cyc.valid && !cyc.we) begin
			s_nxt.rd_strobe = 1'b1;
			s_nxt.rd_status = 1'b1;
			s_nxt.rd_data = '0;
			unique case (s_r.st)
				ST_AUTO: begin
					unique case (cyc.addr[7:0])
						ID_MAKER: s_nxt.rd_data = MAKER_CODE;
						ID_DEV1: s_nxt.rd_data = DEV_CODE1;
						ID_DEV2: s_nxt.rd_data = DEV_CODE2;
						ID_DEV3: s_nxt.rd_data = DEV_CODE3;
						ID_PPB: s_nxt.rd_data = ppb_bit ? PPB_SET_VAL : PPB_CLR_VAL;
						default: s_nxt.rd_status = 1'b0;
					endcase
				end
				ST_NV, ST_NV_CHK: s_nxt.rd_data[0] = nv_bit;
				ST_DYB_STAT: s_nxt.rd_data[1:0] = {s_r.ppb_freeze, dyb_bit};
				ST_PWD: begin
					// A locked password mode never reads the password back
					if (s_r.pwd_op == PWD_OP_VFY && !s_r.pw_lock) begin
						s_nxt.rd_data = cyc.addr[0] ? s_r.password[63:32] : s_r.password[31:0];
					end
					s_nxt.st = idle;
				end
				default: s_nxt.rd_status = 1'b0;
			endcase
		end else if (cyc.valid) begin
			if (d8 == CMD_RESET && !capture) begin
				s_nxt.st = idle;
			end else begin
				unique case (s_r.st)
					ST_READ: begin
						if (unl1) begin
							s_nxt.st = ST_U1;
						end else if (d8 == CMD_SUSP && erase_running && !s_r.erase_chip
							&& !s_r.suspended && bank_ok) begin
							s_nxt.suspended = 1'b1;
							s_nxt.suspend_req = 1'b1;
						end else if (d8 == CMD_RESUME && s_r.suspended && bank_ok) begin
							s_nxt.suspended = 1'b0;
							s_nxt.resume_req = 1'b1;
						end
					end
					ST_U1: s_nxt.st = unl2 ? ST_U2 : idle;
					ST_U2: begin
						s_nxt.st = idle;
						if (at555) begin
							unique case (d8)
								CMD_AUTO: s_nxt.st = ST_AUTO;
								CMD_PGM: s_nxt.st = ST_PGM;
								CMD_ERASE: s_nxt.st = ST_E1;
								CMD_CFG: begin
									if (!embed_busy && !s_r.suspended) begin
										s_nxt.st = ST_CFG;
									end
								end
								CMD_BYP: begin
									s_nxt.bypass = 1'b1;
									s_nxt.st = ST_BYP;
								end
								CMD_SEC_IN: s_nxt.secure_map = 1'b1;
								CMD_PWD_PGM: begin
									s_nxt.pwd_op = PWD_OP_PGM;
									s_nxt.st = ST_PWD;
								end
								CMD_PWD_VFY: begin
									s_nxt.pwd_op = PWD_OP_VFY;
									s_nxt.st = ST_PWD;
								end
								CMD_PWD_UNL: begin
									s_nxt.pwd_op = PWD_OP_UNL;
									s_nxt.st = ST_PWD;
								end
								CMD_NV: s_nxt.st = ST_NV;
								CMD_VOL: s_nxt.st = ST_DYB_WR;
								CMD_VOL_STAT: s_nxt.st = ST_DYB_STAT;
								CMD_FREEZE: s_nxt.ppb_freeze = 1'b1;
								default: s_nxt.st = idle;
							endcase
						end
					end
					ST_AUTO: begin
						if (d8 == CMD_EXIT) begin
							s_nxt.secure_map = 1'b0;
						end
						s_nxt.st = unl1 ? ST_U1 : idle;
					end
					ST_PGM, ST_BYP_PGM: begin
						// Erase-suspend programs must stay out of the erasing sector
						if (!protect && (!embed_busy || s_r.suspended)
							&& !(s_r.suspended && sect_of(cyc.addr) == s_r.erase_sect)) begin
							s_nxt.pgm_req = 1'b1;
							s_nxt.op_addr = cyc.addr;
							s_nxt.op_data = cyc.data;
						end
						s_nxt.st = idle;
					end
					ST_E1: s_nxt.st = unl1 ? ST_E2 : idle;
					ST_E2: s_nxt.st = unl2 ? ST_E3 : idle;
					ST_E3, ST_BYP_ERA: begin
						if (!embed_busy && !s_r.suspended) begin
							if (d8 == CMD_CHIP && (at555 || s_r.st == ST_BYP_ERA)) begin
								s_nxt.erase_req = 1'b1;
								s_nxt.erase_chip = 1'b1;
								s_nxt.op_addr = cyc.addr;
							end else if (d8 == CMD_SECT && s_r.st == ST_E3 && !protect) begin
								s_nxt.erase_req = 1'b1;
								s_nxt.erase_chip = 1'b0;
								s_nxt.erase_sect = sect_of(cyc.addr);
								s_nxt.op_addr = cyc.addr;
							end
						end
						s_nxt.st = idle;
					end
					ST_BYP: begin
						unique case (d8)
							CMD_PGM: s_nxt.st = ST_BYP_PGM;
							CMD_ERASE: s_nxt.st = ST_BYP_ERA;
							CMD_AUTO: s_nxt.st = ST_BYP_RST;
							default: s_nxt.st = ST_BYP;
						endcase
					end
					ST_BYP_RST: begin
						if (d8 == CMD_EXIT) begin
							s_nxt.bypass = 1'b0;
							s_nxt.st = ST_READ;
						end else begin
							s_nxt.st = ST_BYP;
						end
					end
					ST_CFG: begin
						s_nxt.cfg = cyc.data[CFG_W-1:0];
						s_nxt.st = idle;
					end
					ST_PWD: begin
						if (s_r.pwd_op == PWD_OP_PGM) begin
							if (cyc.addr[0]) begin
								s_nxt.password[63:32] = cyc.data;
							end else begin
								s_nxt.password[31:0] = cyc.data;
							end
						end else if (s_r.pwd_op == PWD_OP_UNL) begin
							s_nxt.pwd_ok[cyc.addr[0]] = cyc.addr[0]
								? cyc.data == s_r.password[63:32]
								: cyc.data == s_r.password[31:0];
							if (&s_nxt.pwd_ok) begin
								s_nxt.ppb_freeze = 1'b0;
							end
						end
						s_nxt.st = idle;
					end
					ST_NV: begin
						s_nxt.st = idle;
						if (d8 == CMD_NV_PGM) begin
							s_nxt.st = ST_NV_PROG;
							unique case (pat_of(cyc.addr))
								PAT_PWM: s_nxt.pw_lock = 1'b1;
								PAT_PSM: s_nxt.pers_lock = 1'b1;
								PAT_SEC: s_nxt.secure_lock = 1'b1;
								default: begin
									s_nxt.lw.ppb_set = !s_r.ppb_freeze;
									s_nxt.lw.sect = sect_of(cyc.addr);
								end
							endcase
						end else if (d8 == CMD_NV_ERA && cyc.addr[5:0] == PAT_ALL) begin
							s_nxt.lw.ppb_clr_all = !s_r.ppb_freeze;
							s_nxt.st = ST_NV_ERA;
						end
					end
					ST_NV_PROG: s_nxt.st = d8 == CMD_NV_CHK ? ST_NV_CHK : idle;
					ST_NV_ERA: s_nxt.st = d8 == CMD_NV_ERA_CHK ? ST_NV_CHK : idle;
					ST_DYB_WR: begin
						s_nxt.lw.dyb_we = 1'b1;
						s_nxt.lw.dyb_val = cyc.data[0];
						s_nxt.lw.sect = sect_of(cyc.addr);
						s_nxt.st = idle;
					end
					default: s_nxt.st = unl1 ? ST_U1 : idle;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s_r <= DEC_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rd_strobe = s_r.rd_strobe;
	assign rd_status = s_r.rd_status;
	assign rd_data = s_r.rd_data;
	assign pgm_req = s_r.pgm_req;
	assign erase_req = s_r.erase_req;
	assign erase_chip = s_r.erase_chip;
	assign op_addr = s_r.op_addr;
	assign op_data = s_r.op_data;
	assign suspend_req = s_r.suspend_req;
	assign resume_req = s_r.resume_req;
	assign suspended = s_r.suspended;
	assign bypass = s_r.bypass;
	assign secure_map = s_r.secure_map;
	assign autoselect = s_r.st == ST_AUTO;
	assign cfg = s_r.cfg;
	assign pwd_unlocked = &s_r.pwd_ok;

	// ************************************************
	// Checks
	// ************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence secure_entry_s;
		s_r.st == ST_U2 && cyc.valid && cyc.we && at555 && d8 == CMD_SEC_IN;
	endsequence

	sequence first_unlock_s;
		s_r.st == ST_READ && cyc.valid && cyc.we && cyc.addr[10:0] == UNL_A1
			&& cyc.data[7:0] == CMD_UNL1;
	endsequence

	unlock_low_bits_a: assert property (first_unlock_s |=> s_r.st == ST_U1)
		else $error("unlock cycle not recognised on low bits");
	reset_cmd_a: assert property (cyc.valid && cyc.we && d8 == CMD_RESET && !capture
		|=> (s_r.st == ST_READ || s_r.st == ST_BYP) && $stable(s_r.suspended))
		else $error("reset command did not return to read");
	array_read_a: assert property (s_r.st == ST_READ && cyc.valid && !cyc.we
		|=> rd_strobe && !rd_status)
		else $error("plain read not answered as array");
	suspend_cause_a: assert property (suspend_req |-> $past(erase_running)
		&& !$past(s_r.suspended) && suspended)
		else $error("suspend outside sector erase");
	resume_cause_a: assert property (resume_req |-> $past(s_r.suspended) && !suspended)
		else $error("resume outside suspend");
	cfg_guard_a: assert property (s_r.st == ST_CFG && $past(s_r.st) != ST_CFG
		|-> !$past(embed_busy) && !$past(s_r.suspended))
		else $error("config write accepted while busy");
	secure_entry_a: assert property (secure_entry_s |=> secure_map ##1 secure_map
		|| s_r.st != ST_AUTO)
		else $error("secure area not mapped after entry");
	ppb_status_a: assert property (s_r.st == ST_AUTO && cyc.valid && !cyc.we
		&& cyc.addr[7:0] == ID_PPB |=> rd_data == ($past(ppb_bit) ? PPB_SET_VAL
		: PPB_CLR_VAL) && s_r.st == ST_AUTO)
		else $error("persistent lock status wrong");
	nv_status_a: assert property (s_r.st == ST_NV_CHK && cyc.valid && !cyc.we
		|=> rd_data[0] == $past(nv_bit) && s_r.st == ST_NV_CHK)
		else $error("protection status bit wrong");
	vol_write_a: assert property (s_r.st == ST_DYB_WR && cyc.valid && cyc.we
		|=> s_r.lw.dyb_we && s_r.lw.dyb_val == $past(cyc.data[0]))
		else $error("volatile lock write lost");

endmodule // flash_protection_command_decoder
`default_nettype wire

/* File: host_bus_model.sv */
// Host model that issues write and read cycles to the command decoder
`timescale 1ns/1ns
`default_nettype none
module host_bus_model import flash_cmd_pkg::*; (
	input wire logic ref_clk, // Bus clock
	output bus_cyc_t cyc // Cycle to the decoder
);
	logic noise = 1'b0;
	initial cyc = '0;
	// ****************************************
	// Cycle tasks
	// ****************************************
	// Released lines show the inverse so a stale value is never mistaken for a new one
	task automatic xfer(input logic we, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		#1 cyc = '{1'b1, we, a, d};
		@(posedge ref_clk);
		#1 cyc = '{1'b0, 1'b0, ~a, ~d};
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] c);
		xfer(1'b1, a, {24'h0, c});
	endtask
	// Noise puts junk above the compared unlock bits
	task automatic cmd(input logic [ADDR_W-1:0] a, input logic [7:0] c);
		xfer(1'b1, 20'h00555 | {1'b0, {7{noise}}, 12'h0}, {{24{noise}}, 8'haa});
		xfer(1'b1, 20'h002aa | {1'b0, {7{noise}}, 12'h0}, {{24{noise}}, 8'h55});
		wr(a, c);
	endtask
	// Each password half gets its own full sequence
	task automatic password_word_value(input logic [7:0] c, input logic hf, input logic [31:0] d, input logic we);
		cmd(20'h00555, c);
		xfer(we, {19'h0, hf}, d);
	endtask
endmodule // host_bus_model
`default_nettype wire

/* File: tb_flash_protection_command_decoder.sv */
// Self-checking bench for the flash protection command decoder
`timescale 1ns/1ns
`default_nettype none
module tb_flash_protection_command_decoder import flash_cmd_pkg::*;;
	localparam logic [DATA_W-1:0] MK = 32'h0000_0a5c; // Arbitrary value
	localparam logic [DATA_W-1:0] D1 = 32'h0000_0b61; // Arbitrary value
	localparam logic [DATA_W-1:0] D2 = 32'h0000_0c72; // Arbitrary value
	localparam logic [DATA_W-1:0] D3 = 32'h0000_0d83; // Arbitrary value
	localparam logic [ADDR_W-1:0] S1 = 20'h0c000;
	localparam logic [ADDR_W-1:0] S2 = 20'h84000;
	logic ref_clk = 1'b0, sys_rst = 1'b1, embed_busy = 1'b0, erase_running = 1'b0;
	wire bus_cyc_t cyc;
	logic rd_strobe, rd_status, pgm_req, erase_req, erase_chip, suspend_req, resume_req;
	logic suspended, bypass, secure_map, autoselect, pwd_unlocked;
	logic [DATA_W-1:0] rd_data, op_data;
	logic [ADDR_W-1:0] op_addr;
	logic [CFG_W-1:0] cfg;
	int error_cnt = 0, samples_checked = 0;

	host_bus_model h (.ref_clk(ref_clk), .cyc(cyc));
	flash_protection_command_decoder #(.MAKER_CODE(MK), .DEV_CODE1(D1), .DEV_CODE2(D2),
		.DEV_CODE3(D3)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .cyc(cyc),
		.embed_busy(embed_busy), .erase_running(erase_running), .rd_strobe(rd_strobe),
		.rd_status(rd_status), .rd_data(rd_data), .pgm_req(pgm_req), .erase_req(erase_req),
		.erase_chip(erase_chip), .op_addr(op_addr), .op_data(op_data),
		.suspend_req(suspend_req), .resume_req(resume_req), .suspended(suspended),
		.bypass(bypass), .secure_map(secure_map), .autoselect(autoselect), .cfg(cfg),
		.pwd_unlocked(pwd_unlocked));

	initial forever #50 ref_clk = ~ref_clk;
	// ****************************************
	// Compare and access tasks
	// ****************************************
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic flag(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	// Answer registers at the taking edge, so it is looked at just after it
	task automatic rd(input logic [ADDR_W-1:0] a, input logic st, input logic [DATA_W-1:0] exp);
		h.xfer(1'b0, a, '0);
		flag(rd_strobe, 1'b1);
		flag(rd_status, st);
		if (st) chk(rd_data, exp);
	endtask
	task automatic test_done;
		$display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Whole run is about 1100 cycles, most of it the lock-all loop
	initial begin
		#400000;
		error_cnt++;
		test_done;
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		repeat (6) @(posedge ref_clk);
		#1 sys_rst = 1'b0;
		rd(20'h01234, 1'b0, '0);
		h.noise = 1'b1;
		h.cmd(20'h00555, CMD_SEC_IN);
		h.noise = 1'b0;
		flag(secure_map, 1'b1);
		h.cmd(20'h00555, CMD_AUTO);
		flag(autoselect, 1'b1);
		rd({12'h800, ID_MAKER}, 1'b1, MK);
		rd({12'h800, ID_DEV1}, 1'b1, D1);
		rd({12'h800, ID_DEV2}, 1'b1, D2);
		rd({12'h800, ID_DEV3}, 1'b1, D3);
		h.wr(20'h00000, CMD_EXIT);
		flag(secure_map, 1'b0);
		h.cmd(20'h00555, CMD_AUTO);
		h.wr(20'h3abcd, CMD_RESET);
		flag(autoselect, 1'b0);
		// Broken sequence, then a lone third cycle that must not act
		h.wr(20'h00555, CMD_UNL1);
		h.wr(20'h002aa, CMD_UNL2);
		h.wr(20'h00555, 8'h12);
		h.wr(20'h00555, CMD_SEC_IN);
		flag(secure_map, 1'b0);
		h.cmd(20'h00555, CMD_VOL);
		h.xfer(1'b1, S1, 32'h1);
		h.cmd(20'h00555, CMD_VOL_STAT);
		rd(S1, 1'b1, 32'h1);
		rd(S2, 1'b1, 32'h0);
		h.cmd(20'h00555, CMD_VOL);
		h.xfer(1'b1, S1, 32'hfe);
		h.cmd(20'h00555, CMD_VOL_STAT);
		rd(S1, 1'b1, 32'h0);
		h.cmd(20'h00555, CMD_NV);
		h.wr(S1 | 20'h3a, CMD_NV_PGM);
		h.wr(S1 | 20'h3a, CMD_NV_CHK);
		rd(S1 | 20'h3a, 1'b1, 32'h1);
		h.cmd(20'h00555, CMD_AUTO);
		rd(S1 | 20'h02, 1'b1, PPB_SET_VAL);
		rd(S2 | 20'h02, 1'b1, PPB_CLR_VAL);
		// Every persistent lock is set before the erase-all
		for (int i = 0; i < 64; i++) begin
			h.cmd(20'h00555, CMD_NV);
			h.wr({i[5:0], 14'h3a}, CMD_NV_PGM);
			h.wr({i[5:0], 14'h3a}, CMD_NV_CHK);
			rd({i[5:0], 14'h3a}, 1'b1, 32'h1);
		end
		h.cmd(20'h00555, CMD_NV);
		h.wr(20'h0003a, CMD_NV_ERA);
		h.wr(20'h0003a, CMD_NV_ERA_CHK);
		rd(20'h0003a, 1'b1, 32'h0);
		// Frozen locks refuse a persistent program
		h.cmd(20'h00555, CMD_FREEZE);
		h.cmd(20'h00555, CMD_NV);
		h.wr(S2 | 20'h3a, CMD_NV_PGM);
		h.wr(S2 | 20'h3a, CMD_NV_CHK);
		rd(S2 | 20'h3a, 1'b1, 32'h0);
		h.cmd(20'h00555, CMD_VOL_STAT);
		rd(S2, 1'b1, 32'h2);
		h.wr(20'h00000, CMD_RESET);
		h.password_word_value(CMD_PWD_PGM, 1'b0, 32'h1357_9bdf, 1'b1);
		h.password_word_value(CMD_PWD_PGM, 1'b1, 32'h2468_ace0, 1'b1);
		h.password_word_value(CMD_PWD_VFY, 1'b1, '0, 1'b0);
		chk(rd_data, 32'h2468_ace0);
		h.password_word_value(CMD_PWD_UNL, 1'b0, 32'h1357_9bdf, 1'b1);
		h.password_word_value(CMD_PWD_UNL, 1'b1, 32'h2468_ace1, 1'b1);
		flag(pwd_unlocked, 1'b0);
		h.password_word_value(CMD_PWD_UNL, 1'b1, 32'h2468_ace0, 1'b1);
		flag(pwd_unlocked, 1'b1);
		h.cmd(20'h00555, CMD_NV);
		h.wr(20'h00012, CMD_NV_PGM);
		h.wr(20'h00012, CMD_NV_CHK);
		rd(20'h00012, 1'b1, 32'h1);
		h.cmd(20'h00555, CMD_NV);
		h.wr(20'h0001a, CMD_NV_PGM);
		h.wr(20'h0001a, CMD_NV_CHK);
		h.cmd(20'h00555, CMD_NV);
		rd(20'h0000a, 1'b1, 32'h0);
		rd(20'h0001a, 1'b1, 32'h1);
		h.wr(20'h00000, CMD_RESET);
		h.wr(20'h00000, CMD_PGM);
		h.xfer(1'b1, S2, 32'hcafe_0001);
		flag(pgm_req, 1'b0);
		h.cmd(20'h00555, CMD_BYP);
		flag(bypass, 1'b1);
		h.wr(20'h00000, CMD_PGM);
		h.xfer(1'b1, S2, 32'hcafe_0001);
		flag(pgm_req, 1'b1);
		chk(op_data, 32'hcafe_0001);
		h.wr(20'h00000, CMD_ERASE);
		h.wr(20'h00000, CMD_CHIP);
		flag(erase_req, 1'b1);
		flag(erase_chip, 1'b1);
		h.wr(20'h00000, CMD_AUTO);
		h.wr(20'h00000, CMD_EXIT);
		flag(bypass, 1'b0);
		h.wr(S2, CMD_SUSP);
		flag(suspend_req, 1'b0);
		h.cmd(20'h00555, CMD_ERASE);
		h.cmd(S2, CMD_SECT);
		flag(erase_req, 1'b1);
		flag(erase_chip, 1'b0);
		chk({12'h0, op_addr}, {12'h0, S2});
		embed_busy = 1'b1;
		erase_running = 1'b1;
		h.wr(S1, CMD_SUSP);
		flag(suspend_req, 1'b0);
		h.wr(S2, CMD_SUSP);
		flag(suspend_req, 1'b1);
		h.wr(20'h00000, CMD_RESET);
		flag(suspended, 1'b1);
		embed_busy = 1'b0;
		erase_running = 1'b0;
		h.cmd(20'h00555, CMD_PGM);
		h.xfer(1'b1, S1 | 20'h10, 32'h5);
		flag(pgm_req, 1'b1);
		h.cmd(20'h00555, CMD_CFG);
		h.xfer(1'b1, 20'h00000, 32'h1234);
		chk({16'h0, cfg}, 32'h0);
		h.wr(S1, CMD_RESUME);
		flag(resume_req, 1'b0);
		h.wr(S2, CMD_RESUME);
		flag(resume_req, 1'b1);
		flag(suspended, 1'b0);
		h.cmd(20'h00555, CMD_CFG);
		h.xfer(1'b1, 20'h00000, 32'h1234);
		chk({16'h0, cfg}, 32'h1234);
		// A chip erase cannot be suspended
		h.cmd(20'h00555, CMD_ERASE);
		h.cmd(20'h00555, CMD_CHIP);
		flag(erase_chip, 1'b1);
		erase_running = 1'b1;
		h.wr(S2, CMD_SUSP);
		flag(suspend_req, 1'b0);
		erase_running = 1'b0;
		test_done;
	end
endmodule // tb_flash_protection_command_decoder
`default_nettype wire
